// file: drf_regfile.sv
// Register file with special-function registers, banked storage and port access
`timescale 1ns/1ns
`default_nettype none
module drf_regfile
    import drf_pkg::*;
#(
    parameter int  NPORT      = DRF_NPORT,
    parameter int  NBANK_BITS = DRF_BANK_W,
    parameter bit  BANKED_EN  = 1'b1
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              clk_en,
    // Core request, one per instruction cycle
    input  wire drf_op_e           op,
    input  wire logic [DRF_AW-1:0] addr,
    input  wire logic [DRF_DW-1:0] wdata,
    input  wire logic [DRF_BIT_W-1:0] bit_sel,
    input  wire logic [DRF_DW-1:0] pc_low,
    output var  logic [DRF_DW-1:0] rdata,
    // Status and option
    output var  logic [DRF_DW-1:0] status_q,
    output var  logic [DRF_DW-1:0] option_q,
    // Port pins
    input  wire logic [NPORT*DRF_DW-1:0] pin_in,
    output var  logic [NPORT*DRF_DW-1:0] pin_out,
    output var  logic [NPORT*DRF_DW-1:0] pin_oe
);
    localparam int NB   = 1 << NBANK_BITS;
    localparam int NLOC = NB * DRF_BANKED;
    localparam int OFS_W = $clog2(DRF_BANKED);
    localparam int SHR_W = $clog2(DRF_BANKED/2);

    // Storage
    logic [DRF_DW-1:0] gpr_ff [NLOC];
    logic [DRF_DW-1:0] nxt_gpr [NLOC];
    logic [DRF_DW-1:0] shared_ff [DRF_BANKED/2];
    logic [DRF_DW-1:0] nxt_shared [DRF_BANKED/2];
    logic [DRF_DW-1:0] spare_ff;
    logic [DRF_DW-1:0] nxt_spare;
    // Special registers
    logic [DRF_DW-1:0] timer_ff;
    logic [DRF_DW-1:0] nxt_timer;
    logic [DRF_DW-1:0] status_ff;
    logic [DRF_DW-1:0] nxt_status;
    logic [DRF_DW-1:0] pointer_ff;
    logic [DRF_DW-1:0] nxt_pointer;
    logic [DRF_DW-1:0] option_ff;
    logic [DRF_DW-1:0] nxt_option;

    // Decode and datapath
    logic [DRF_AW-1:0] eff_addr;
    logic [NBANK_BITS-1:0] bank;
    logic [DRF_DW-1:0] rd_val;
    logic [DRF_DW-1:0] mod_val;
    logic              wr;
    logic [NPORT-1:0]  latch_we;
    logic [NPORT-1:0]  dir_we;

    // Port number of an address, or NPORT when not a port
    function automatic int port_of(input logic [DRF_AW-1:0] a);
        int r;
        r = NPORT;
        if (a >= DRF_A_PORT0 && a < DRF_A_PORT0 + NPORT[DRF_AW-1:0])
            r = int'(a - DRF_A_PORT0);
        return r;
    endfunction

    // Smallest variant keeps a general register where the third port would sit
    function automatic logic is_spare(input logic [DRF_AW-1:0] a);
        return (NPORT < DRF_NPORT) && (a == DRF_A_PORT2);
    endfunction

    // Banked storage from the bank base up
    function automatic logic is_banked(input logic [DRF_AW-1:0] a);
        return a >= DRF_A_BANK_BASE;
    endfunction

    function automatic logic is_shared(input logic [DRF_AW-1:0] a);
        return (a >= DRF_A_GPR_BASE) && (a <= DRF_A_SHARED_TOP);
    endfunction

    // Indirect addressing through the pointer
    always_comb begin
        eff_addr = (addr == DRF_A_INDIRECT) ? pointer_ff[DRF_AW-1:0] : addr;
        bank = BANKED_EN ? pointer_ff[DRF_PTR_BANK_LSB +: NBANK_BITS] : '0;
    end

    // Read mux; port reads see the pins as sampled this cycle
    always_comb begin
        rd_val = DRF_ZERO_BYTE;
        if (port_of(eff_addr) < NPORT) begin
            rd_val = pin_in[port_of(eff_addr)*DRF_DW +: DRF_DW];
        end else begin
            case (eff_addr)
                DRF_A_INDIRECT: rd_val = DRF_ZERO_BYTE;
                DRF_A_TIMER:    rd_val = timer_ff;
                DRF_A_PCL:      rd_val = pc_low;
                DRF_A_STATUS:   rd_val = status_ff;
                DRF_A_POINTER:  rd_val = pointer_ff;
                default: begin
                    if (is_banked(eff_addr))
                        rd_val = gpr_ff[{bank, eff_addr[OFS_W-1:0]}];
                    else if (is_shared(eff_addr))
                        rd_val = shared_ff[eff_addr[SHR_W-1:0]];
                    else if (is_spare(eff_addr))
                        rd_val = spare_ff;
                    else
                        rd_val = DRF_ZERO_BYTE;
                end
            endcase
        end
    end

    // Read-modify-write: whole byte read, one bit changed, whole byte written
    always_comb begin
        mod_val = wdata;
        wr = 1'b0;
        case (op)
            DRF_OP_WRITE: begin
                wr = 1'b1;
            end
            DRF_OP_BIT_CLEAR: begin
                mod_val = rd_val & ~(DRF_ONE_BYTE << bit_sel);
                wr = 1'b1;
            end
            DRF_OP_BIT_SET: begin
                mod_val = rd_val | (DRF_ONE_BYTE << bit_sel);
                wr = 1'b1;
            end
            default: begin
                wr = 1'b0;
            end
        endcase
    end

    // Next state of the special and general registers
    always_comb begin
        nxt_timer   = timer_ff + DRF_ONE_BYTE;
        nxt_status  = status_ff;
        nxt_pointer = pointer_ff;
        nxt_option  = (op == DRF_OP_LOAD_OPTION) ? wdata : option_ff;
        nxt_gpr     = gpr_ff;
        nxt_shared  = shared_ff;
        nxt_spare   = spare_ff;
        if (wr) begin
            case (eff_addr)
                DRF_A_TIMER:   nxt_timer = mod_val;
                DRF_A_STATUS:  nxt_status = mod_val;
                DRF_A_POINTER: nxt_pointer = mod_val;
                default: begin
                    if (is_banked(eff_addr))
                        nxt_gpr[{bank, eff_addr[OFS_W-1:0]}] = mod_val;
                    else if (is_shared(eff_addr))
                        nxt_shared[eff_addr[SHR_W-1:0]] = mod_val;
                    else if (is_spare(eff_addr))
                        nxt_spare = mod_val;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            timer_ff   <= DRF_ZERO_BYTE;
            status_ff  <= DRF_STATUS_RST;
            pointer_ff <= DRF_POINTER_RST;
            option_ff  <= DRF_OPTION_RST;
            for (int i = 0; i < NLOC; i++) gpr_ff[i] <= DRF_ZERO_BYTE;
            for (int i = 0; i < DRF_BANKED/2; i++) shared_ff[i] <= DRF_ZERO_BYTE;
            spare_ff   <= DRF_ZERO_BYTE;
        end else if (clk_en) begin
            timer_ff   <= nxt_timer;
            status_ff  <= nxt_status;
            pointer_ff <= nxt_pointer;
            option_ff  <= nxt_option;
            gpr_ff     <= nxt_gpr;
            shared_ff  <= nxt_shared;
            spare_ff   <= nxt_spare;
        end
    end

    // Read data registered, available the cycle after the request
    logic [DRF_DW-1:0] rdata_ff;
    logic [DRF_DW-1:0] nxt_rdata;

    always_comb begin
        nxt_rdata = rd_val;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= DRF_ZERO_BYTE;
        end else if (clk_en) begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign rdata    = rdata_ff;
    assign status_q = status_ff;
    assign option_q = option_ff;

    // Ports
    genvar p;
    generate
        for (p = 0; p < NPORT; p++) begin : g_port
            assign latch_we[p] = wr && (port_of(eff_addr) == p);
            assign dir_we[p]   = (op == DRF_OP_LOAD_DIR) && (port_of(addr) == p);
            drf_port #(.W(DRF_DW)) u_port (
                .sys_clk   (sys_clk),
                .rst       (rst),
                .clk_en    (clk_en),
                .latch_we  (latch_we[p]),
                .latch_din (mod_val),
                .dir_we    (dir_we[p]),
                .dir_din   (wdata),
                .latch_q   (),
                .dir_q     (),
                .pin_out   (pin_out[p*DRF_DW +: DRF_DW]),
                .pin_oe    (pin_oe[p*DRF_DW +: DRF_DW])
            );
        end
    endgenerate
endmodule : drf_regfile
`default_nettype wire

// file: drf_pkg.sv
// Constants and types for the data register file with port read-modify-write
package drf_pkg;
    // Contract
    // - Data memory is a register file of special-function and general-purpose registers.
    // - Timer, program counter, status, ports and indirect pointer are special-function registers.
    // - Smallest variant: 7 special-function plus 25 general-purpose registers, 32 locations.
    // - Third-port variant: 8 special-function plus 24 general-purpose registers.
    // - Larger variants add up to 48 banked general-purpose registers.
    // - Every location is reachable directly or through the indirect pointer.
    // - Bit set or clear on a port reads all bits, changes one, writes whole byte.
    // - Input pins being read during such an operation load their level into the latch.
    // - Input pins are unaffected by latch writes until switched to output.
    // - Clearing bit 7 then 6 on pulled-up inputs leaves latch 7:6 at 10.
    // - Port writes land at cycle end; port reads sample pins at cycle start (here reads sample pins at the clock edge that ends the cycle).

    localparam int DRF_DW      = 8;
    localparam int DRF_AW      = 5;
    localparam int DRF_BANK_W  = 2;
    localparam int DRF_BIT_W   = 3;
    localparam int DRF_NPORT   = 3;
    localparam int DRF_DEPTH   = 32;
    localparam int DRF_BANKED  = 16;

    // Special-function register addresses and general-register region bounds
    localparam logic [4:0] DRF_A_INDIRECT = 5'h00;
    localparam logic [4:0] DRF_A_TIMER    = 5'h01;
    localparam logic [4:0] DRF_A_PCL      = 5'h02;
    localparam logic [4:0] DRF_A_STATUS   = 5'h03;
    localparam logic [4:0] DRF_A_POINTER  = 5'h04;
    localparam logic [4:0] DRF_A_PORT0    = 5'h05;
    localparam logic [4:0] DRF_A_PORT2    = 5'h07;
    localparam logic [4:0] DRF_A_GPR_BASE = 5'h08;
    localparam logic [4:0] DRF_A_SHARED_TOP = 5'h0f;
    localparam logic [4:0] DRF_A_BANK_BASE  = 5'h10;

    localparam logic [7:0] DRF_ZERO_BYTE   = 8'h00;
    localparam logic [7:0] DRF_ALL_INPUT   = 8'hff;
    localparam logic [7:0] DRF_STATUS_RST  = 8'h18;
    localparam logic [7:0] DRF_OPTION_RST  = 8'h3f;
    localparam logic [7:0] DRF_POINTER_RST = 8'he0;
    localparam logic [7:0] DRF_ONE_BYTE    = 8'h01;
    localparam int         DRF_PTR_BANK_LSB = 5;

    typedef enum logic [2:0] {
        DRF_OP_NONE,
        DRF_OP_WRITE,
        DRF_OP_BIT_CLEAR,
        DRF_OP_BIT_SET,
        DRF_OP_LOAD_DIR,
        DRF_OP_LOAD_OPTION
    } drf_op_e;
endpackage : drf_pkg

// file: drf_port.sv
// One bidirectional port: output latch, direction register and pin drivers
`timescale 1ns/1ns
`default_nettype none
module drf_port
    import drf_pkg::*;
#(
    parameter int W = DRF_DW
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         clk_en,
    // Core side
    input  wire logic         latch_we,
    input  wire logic [W-1:0] latch_din,
    input  wire logic         dir_we,
    input  wire logic [W-1:0] dir_din,
    output var  logic [W-1:0] latch_q,
    output var  logic [W-1:0] dir_q,
    // Pins
    output var  logic [W-1:0] pin_out,
    output var  logic [W-1:0] pin_oe
);
    logic [W-1:0] latch_ff;
    logic [W-1:0] nxt_latch;
    logic [W-1:0] dir_ff;
    logic [W-1:0] nxt_dir;

    always_comb begin
        nxt_latch = latch_we ? latch_din : latch_ff;
        nxt_dir   = dir_we ? dir_din : dir_ff;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            latch_ff <= '0;
            dir_ff   <= '1;
        end else if (clk_en) begin
            latch_ff <= nxt_latch;
            dir_ff   <= nxt_dir;
        end
    end

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_pin
            assign pin_oe[g] = ~dir_ff[g];
        end
    endgenerate

    assign pin_out = latch_ff;
    assign latch_q = latch_ff;
    assign dir_q   = dir_ff;
endmodule : drf_port
`default_nettype wire

// file: drf_regfile_properties.sv
// Checker for the register file ports
`timescale 1ns/1ns
`default_nettype none
module drf_regfile_properties
    import drf_pkg::*;
#(
    parameter int NPORT = DRF_NPORT
) (
    // Clock, reset and request
    input wire logic              sys_clk,
    input wire logic              rst,
    input wire logic              clk_en,
    input wire drf_op_e           op,
    input wire logic [4:0]        addr,
    input wire logic [7:0]        wdata,
    input wire logic [2:0]        bit_sel,
    input wire logic [7:0]        pc_low,
    // Results and pins
    input wire logic [7:0]        rdata,
    input wire logic [7:0]        option_q,
    input wire logic [NPORT*8-1:0] pin_in,
    input wire logic [NPORT*8-1:0] pin_out,
    input wire logic [NPORT*8-1:0] pin_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    bit_clear_a: assert property (clk_en && op == DRF_OP_BIT_CLEAR && addr == 5'h06
        |=> pin_out[15:8] == ($past(pin_in[15:8]) & ~(8'h01 << $past(bit_sel))))
        else $error("bit clear result wrong");
    bit_set_a: assert property (clk_en && op == DRF_OP_BIT_SET && addr == 5'h05
        |=> pin_out[7:0] == ($past(pin_in[7:0]) | (8'h01 << $past(bit_sel))))
        else $error("bit set result wrong");
    dir_load_a: assert property (clk_en && op == DRF_OP_LOAD_DIR && addr == 5'h06
        |=> pin_oe[15:8] == ~$past(wdata)) else $error("direction wrong");
    port_write_a: assert property (clk_en && op == DRF_OP_WRITE && addr == 5'h07
        |=> pin_out[23:16] == $past(wdata)) else $error("port write wrong");
    pc_read_a: assert property (clk_en && addr == DRF_A_PCL
        |=> rdata == $past(pc_low)) else $error("pc read wrong");
    idle_hold_a: assert property (clk_en && op == DRF_OP_NONE |=>
        $stable(pin_out) && $stable(pin_oe)) else $error("idle changed port");
    freeze_a: assert property (!clk_en |=> $stable(pin_out) && $stable(rdata))
        else $error("frozen cycle changed state");
    reset_val_a: assert property (disable iff (1'b0) rst |->
        pin_oe == '0 && option_q == DRF_OPTION_RST) else $error("reset value wrong");
    cover property (clk_en && op == DRF_OP_BIT_CLEAR);
    cover property (clk_en && op == DRF_OP_BIT_SET);
    cover property (clk_en && op == DRF_OP_LOAD_DIR);
endmodule // drf_regfile_properties
bind drf_regfile drf_regfile_properties #(.NPORT(NPORT)) drf_regfile_properties_i (.sys_clk,
    .rst, .clk_en, .op, .addr, .wdata, .bit_sel, .pc_low, .rdata, .option_q, .pin_in,
    .pin_out, .pin_oe);
`default_nettype wire

// file: drf_pins_model.sv
// Port pins with pull-ups and an external driver
`timescale 1ns/1ns
`default_nettype none
module drf_pins_model (
    // From the block
    input  wire logic [23:0] pin_out,
    input  wire logic [23:0] pin_oe,
    // External driver
    input  wire logic [23:0] ext_en,
    input  wire logic [23:0] ext_val,
    // To the block
    output logic [23:0]      pin_in
);
    // Driven pins show the latch, released pins the outside level or pull-up
    logic [23:0] outside;
    assign outside = (ext_en & ext_val) | ~ext_en;
    assign pin_in  = (pin_oe & pin_out) | (~pin_oe & outside);
endmodule // drf_pins_model
`default_nettype wire

// file: drf_regfile_tb.sv
// Testbench for the register file and port read-modify-write
`timescale 1ns/1ns
`default_nettype none
module drf_regfile_tb
    import drf_pkg::*;
;
    logic        sys_clk, rst, clk_en;
    drf_op_e     op;
    logic [4:0]  addr;
    logic [2:0]  bit_sel;
    logic [7:0]  wdata, pc_low, rdata, status_q, option_q;
    logic [23:0] pin_in, pin_out, pin_oe, ext_en, ext_val;
    int          fails, comparisons;
    drf_regfile drf_regfile_i (.sys_clk, .rst, .clk_en, .op, .addr, .wdata, .bit_sel,
        .pc_low, .rdata, .status_q, .option_q, .pin_in, .pin_out, .pin_oe);
    drf_pins_model drf_pins_model_i (.pin_out, .pin_oe, .ext_en, .ext_val, .pin_in);
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input drf_op_e o, input logic [4:0] a, input logic [7:0] d,
                       input logic [2:0] b);
        op = o;
        addr = a;
        wdata = d;
        bit_sel = b;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic t_rmw_inputs;
        ext_en = 24'h002000;
        cyc(DRF_OP_LOAD_DIR, 5'h06, 8'hf0, 3'h0);
        chk(pin_oe[15:8], 8'h0f);
        cyc(DRF_OP_BIT_CLEAR, 5'h06, 8'h00, 3'h7);
        chk(pin_out[15:8], 8'h50);
        cyc(DRF_OP_BIT_CLEAR, 5'h06, 8'h00, 3'h6);
        chk(pin_out[15:8], 8'h90);
        chk(pin_in[15:8], 8'hd0);
        cyc(DRF_OP_LOAD_DIR, 5'h06, 8'h3f, 3'h0);
        chk(pin_oe[15:8], 8'hc0);
        chk(pin_in[15:8], 8'h9f);
    endtask
    task automatic t_bit_set;
        cyc(DRF_OP_LOAD_DIR, 5'h05, 8'h00, 3'h0);
        for (int b = 0; b < 8; b++) begin
            cyc(DRF_OP_BIT_SET, 5'h05, 8'h00, b[2:0]);
            chk(pin_out[7:0], 8'hff >> (7 - b));
        end
    endtask
    task automatic t_write_read;
        cyc(DRF_OP_LOAD_DIR, 5'h07, 8'h00, 3'h0);
        cyc(DRF_OP_WRITE, 5'h07, 8'h5a, 3'h0);
        chk(pin_out[23:16], 8'h5a);
        clk_en = 1'b0;
        cyc(DRF_OP_WRITE, 5'h07, 8'h11, 3'h0);
        chk(pin_out[23:16], 8'h5a);
        clk_en = 1'b1;
        cyc(DRF_OP_NONE, 5'h08, 8'h00, 3'h0);
        cyc(DRF_OP_NONE, 5'h07, 8'h00, 3'h0);
        chk(rdata, 8'h5a);
        ext_en = 24'hff2000;
        ext_val = 24'hc30000;
        cyc(DRF_OP_LOAD_DIR, 5'h07, 8'hff, 3'h0);
        cyc(DRF_OP_NONE, 5'h07, 8'h00, 3'h0);
        chk(rdata, 8'hc3);
        chk(pin_out[23:16], 8'h5a);
    endtask
    task automatic t_indirect;
        cyc(DRF_OP_WRITE, DRF_A_POINTER, 8'h30, 3'h0);
        cyc(DRF_OP_WRITE, 5'h00, 8'h77, 3'h0);
        cyc(DRF_OP_WRITE, 5'h09, 8'ha5, 3'h0);
        cyc(DRF_OP_NONE, 5'h10, 8'h00, 3'h0);
        chk(rdata, 8'h77);
        cyc(DRF_OP_WRITE, DRF_A_POINTER, 8'h09, 3'h0);
        cyc(DRF_OP_NONE, 5'h00, 8'h00, 3'h0);
        chk(rdata, 8'ha5);
        cyc(DRF_OP_NONE, 5'h10, 8'h00, 3'h0);
        chk(rdata, 8'h00);
        cyc(DRF_OP_NONE, DRF_A_PCL, 8'h00, 3'h0);
        chk(rdata, 8'h9c);
    endtask
    task automatic t_storage;
        cyc(DRF_OP_WRITE, DRF_A_POINTER, 8'h00, 3'h0);
        for (int a = 8; a < 32; a++)
            cyc(DRF_OP_WRITE, a[4:0], 8'ha0 ^ a[7:0], 3'h0);
        for (int a = 8; a < 32; a++) begin
            cyc(DRF_OP_NONE, a[4:0], 8'h00, 3'h0);
            chk(rdata, 8'ha0 ^ a[7:0]);
        end
        cyc(DRF_OP_WRITE, DRF_A_POINTER, 8'h30, 3'h0);
        cyc(DRF_OP_NONE, 5'h10, 8'h00, 3'h0);
        chk(rdata, 8'h77);
    endtask
    task automatic t_special;
        cyc(DRF_OP_LOAD_OPTION, 5'h08, 8'h07, 3'h0);
        chk(option_q, 8'h07);
        cyc(DRF_OP_WRITE, DRF_A_STATUS, 8'h5c, 3'h0);
        cyc(DRF_OP_BIT_SET, DRF_A_STATUS, 8'h00, 3'h1);
        chk(status_q, 8'h5e);
        cyc(DRF_OP_WRITE, DRF_A_TIMER, 8'h40, 3'h0);
        cyc(DRF_OP_NONE, DRF_A_TIMER, 8'h00, 3'h0);
        chk(rdata, 8'h40);
        cyc(DRF_OP_NONE, DRF_A_TIMER, 8'h00, 3'h0);
        chk(rdata, 8'h41);
        clk_en = 1'b0;
        cyc(DRF_OP_NONE, DRF_A_TIMER, 8'h00, 3'h0);
        chk(rdata, 8'h41);
        clk_en = 1'b1;
        cyc(DRF_OP_NONE, DRF_A_TIMER, 8'h00, 3'h0);
        chk(rdata, 8'h42);
    endtask
    task automatic conclude;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (1000) @(posedge sys_clk);
        fails++;
        conclude();
    end
    initial begin
        fails = 0;
        comparisons = 0;
        rst = 1'b1;
        clk_en = 1'b1;
        op = DRF_OP_NONE;
        addr = 5'h08;
        wdata = 8'h00;
        bit_sel = 3'h0;
        pc_low = 8'h9c;
        ext_en = 24'h0;
        ext_val = 24'h0;
        repeat (2) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        chk(pin_oe[15:8], 8'h00);
        chk(option_q, DRF_OPTION_RST);
        chk(status_q, DRF_STATUS_RST);
        t_rmw_inputs();
        t_bit_set();
        t_write_read();
        t_indirect();
        t_storage();
        t_special();
        conclude();
    end
endmodule // drf_regfile_tb
`default_nettype wire
